// >>> rtl/uvp_defines.svh
// Summary of operation
// [RL1] five node operating modes, status shows effective
// [RL2] force setting overrides reported status
// [RL3] mode and force never bank-switched
// [RL4] pick-up threshold in 0.01% steps, 60%
// [RL5] ratio per voltage computed continuously
// [RL6] release at fixed 103% of threshold
// [RL7] one threshold, any of three voltages
// [RL8] pick-up alone never asserts start
// [RL9] block level setting, zero disables it
// [RL10] low-voltage block latched until all recover
// [RL11] pick-up and block levels in primary volts
// [RL12] expected operating time, recomputed for inverse time
// [RL13] remaining time to trip, 5 ms steps
// [RL14] per-phase and lowest ratio, 0.01 steps
// [RL15] external block sampled each program cycle
// [RL16] unblocked pick-up asserts start, starts timing
// [RL17] blocked pick-up asserts blocked, nothing more
// [RL18] blocking during start drops start, resets timing
// [RL19] blocking raises display and stamped event
// [RL20] source blocks at least 5 ms early
// [RL21] four independent stages
// [RL22] event stamps in 1 ms resolution
// [RL23] below threshold picks up, releases above hysteresis
`ifndef UVP_DEFINES_SVH
`define UVP_DEFINES_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define UVP_CLK_HZ      32'h0098_9680
`define UVP_PROG_US     32'h0000_1388
`define UVP_MS_US       32'h0000_03e8
`define UVP_PROG_CYCLES ((`UVP_CLK_HZ / 32'h000f_4240) * `UVP_PROG_US)
`define UVP_MS_CYCLES   ((`UVP_CLK_HZ / 32'h000f_4240) * `UVP_MS_US)
`define UVP_OP_MAX      32'h0005_7e40

// ----------------------------------------
// codes and scaling
// ----------------------------------------
`define UVP_MODE_ON      3'h1
`define UVP_MODE_BLOCKED 3'h2
`define UVP_MODE_TEST    3'h3
`define UVP_MODE_TESTBLK 3'h4
`define UVP_MODE_OFF     3'h5
`define UVP_FORCE_NORMAL 2'h0
`define UVP_FORCE_START  2'h1
`define UVP_FORCE_TRIP   2'h2
`define UVP_FORCE_BLOCK  2'h3
`define UVP_HYST_PCT     24'h00_0067
`define UVP_PCT_FULL     24'h00_0064
`define UVP_PU_FULL      48'h0000_0000_2710

// ----------------------------------------
// reset values
// ----------------------------------------
`define UVP_PICKUP_RST   16'h1770
`define UVP_BLKLVL_RST   16'h03e8
`define UVP_OPDLY_RST    32'h0000_0008
`define UVP_DIAL_RST     32'h0000_000a
`define UVP_VTPRI_RST    32'h0000_2710

// ----------------------------------------
// register offsets, stage block in addr[7:4]
// ----------------------------------------
`define UVP_REG_MODE     4'h0
`define UVP_REG_FORCE    4'h1
`define UVP_REG_PICKUP   4'h2
`define UVP_REG_BLKLVL   4'h3
`define UVP_REG_DTYPE    4'h4
`define UVP_REG_OPDLY    4'h5
`define UVP_REG_DIAL     4'h6
`define UVP_REG_STATUS   4'h7
`define UVP_REG_RATIO0   4'h8
`define UVP_REG_RATIO1   4'h9
`define UVP_REG_RATIO2   4'ha
`define UVP_REG_RATIOMIN 4'hb
`define UVP_REG_EXPECT   4'hc
`define UVP_REG_REMAIN   4'hd
`define UVP_REG_PUPRI    4'he
`define UVP_REG_BLKPRI   4'hf
`define UVP_GLOBAL_SEL   4'h4
`define UVP_REG_VTPRI    4'h0
`define UVP_REG_STAMP    4'h1

// ----------------------------------------
// status field positions
// ----------------------------------------
`define UVP_ST_PICKUP    3
`define UVP_ST_START     4
`define UVP_ST_TRIP      5
`define UVP_ST_BLOCKED   6
`define UVP_ST_UVBLOCK   7
`define UVP_ST_EXTBLK    8

`endif

// >>> rtl/uvp_pkg.sv
`default_nettype none
package uvp_pkg;
	// stage decision state
	typedef enum logic [1:0] {UVP_IDLE, UVP_START, UVP_BLOCKED} uvp_state_type;
	// ratio and timing calculation steps
	typedef enum logic [2:0] {SEQ_IDLE, SEQ_PH0, SEQ_PH1, SEQ_PH2, SEQ_INV} uvp_seq_type;
endpackage : uvp_pkg
`default_nettype wire

// >>> rtl/uvp_div_if.sv
`default_nettype none
interface uvp_div_if #(parameter int W = 32);
	logic         go;
	logic [W-1:0] num;
	logic [W-1:0] den;
	logic [W-1:0] quo;
	logic         done;
	modport master (output go, output num, output den, input quo, input done);
	modport slave  (input go, input num, input den, output quo, output done);
endinterface : uvp_div_if
`default_nettype wire

// >>> rtl/uvp_divider.sv
`default_nettype none
module uvp_divider #(
	parameter int W = 32
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	uvp_div_if.slave dv
);
	logic [W-1:0]         rem;
	logic [W-1:0]         quo;
	logic [W-1:0]         den;
	logic [W:0]           trial;
	logic [$clog2(W+1)-1:0] cnt;
	logic                 busy;

	// trial subtraction of one restoring step
	always_comb begin
		trial = {rem, quo[W-1]} - {1'b0, den};
	end

	// ----------------------------------------
	// serial restoring division, one bit a cycle
	// ----------------------------------------
	// area traded for time: a program cycle leaves thousands of spare clocks
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rem     <= '0;
			quo     <= '0;
			den     <= '0;
			cnt     <= '0;
			busy    <= 1'b0;
			dv.done <= 1'b0;
		end else begin
			dv.done <= 1'b0;
			if (dv.go && !busy) begin
				rem <= '0;
				den <= dv.den;
				cnt <= ($clog2(W+1))'(W);
				// divide by zero saturates instead of hanging
				if (dv.den == '0) begin
					quo     <= '1;
					dv.done <= 1'b1;
				end else begin
					quo  <= dv.num;
					busy <= 1'b1;
				end
			end else if (busy) begin
				if (!trial[W]) begin
					rem <= trial[W-1:0];
					quo <= {quo[W-2:0], 1'b1};
				end else begin
					rem <= {rem[W-2:0], quo[W-1]};
					quo <= {quo[W-2:0], 1'b0};
				end
				cnt <= cnt - 1'b1;
				if (cnt == ($clog2(W+1))'(1)) begin
					busy    <= 1'b0;
					dv.done <= 1'b1;
				end
			end
		end
	end

	assign dv.quo = quo;
endmodule : uvp_divider
`default_nettype wire

// >>> rtl/uvp_stage.sv
`default_nettype none
`include "uvp_defines.svh"
module uvp_stage #(
	parameter int NUM_STAGES  = 4,
	parameter int PROG_CYCLES = `UVP_PROG_CYCLES,
	parameter int MS_CYCLES   = `UVP_MS_CYCLES
) (
	input  wire logic                  ref_clk,
	input  wire logic                  reset_n,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output var  logic [31:0]           reg_rdata,
	input  wire logic [2:0][15:0]      measured_voltage,
	input  wire logic [3:0]            block_in,
	output wire logic [3:0]            start_out,
	output wire logic [3:0]            trip_out,
	output wire logic [3:0]            blocked_out,
	output wire logic [3:0]            display_event,
	output wire logic [3:0]            block_event,
	output wire logic [3:0][31:0]      event_stamp,
	output wire logic [3:0][2:0][15:0] event_voltage,
	output wire logic [3:0][2:0]       event_fault_type
);
	// ----------------------------------------
	// program cycle and millisecond time base
	// ----------------------------------------
	logic [31:0] prog_cnt;
	logic [31:0] ms_cnt;
	logic [31:0] ms_time;
	logic        prog_tick;
	logic        ms_tick;
	logic [31:0] vt_primary;
	logic [15:0] v_min;
	wire  [31:0] stage_rd [NUM_STAGES];

	// program cycle divider
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			prog_cnt  <= '0;
			prog_tick <= 1'b0;
		end else begin
			prog_tick <= (prog_cnt == 32'(PROG_CYCLES - 1));
			prog_cnt  <= (prog_cnt == 32'(PROG_CYCLES - 1)) ? '0 : prog_cnt + 32'h1;
		end
	end

	// [RL22] millisecond stamp
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ms_cnt  <= '0;
			ms_tick <= 1'b0;
			ms_time <= '0;
		end else begin
			ms_tick <= (ms_cnt == 32'(MS_CYCLES - 1));
			ms_cnt  <= (ms_cnt == 32'(MS_CYCLES - 1)) ? '0 : ms_cnt + 32'h1;
			if (ms_tick)
				ms_time <= ms_time + 32'h1;
		end
	end

	// lowest monitored voltage
	always_comb begin
		v_min = measured_voltage[0];
		if (measured_voltage[1] < v_min)
			v_min = measured_voltage[1];
		if (measured_voltage[2] < v_min)
			v_min = measured_voltage[2];
	end

	// transformer scaling shared by all stages
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			vt_primary <= `UVP_VTPRI_RST;
		else if (reg_wr && reg_addr[7:4] == `UVP_GLOBAL_SEL && reg_addr[3:0] == `UVP_REG_VTPRI)
			vt_primary <= reg_wdata;
	end

	// read data valid in the cycle after the strobe only
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			reg_rdata <= '0;
		else if (!reg_rd)
			reg_rdata <= '0;
		else if (reg_addr[7:4] < 4'(NUM_STAGES))
			reg_rdata <= stage_rd[reg_addr[5:4]];
		else if (reg_addr[7:4] == `UVP_GLOBAL_SEL && reg_addr[3:0] == `UVP_REG_VTPRI)
			reg_rdata <= vt_primary;
		else if (reg_addr[7:4] == `UVP_GLOBAL_SEL && reg_addr[3:0] == `UVP_REG_STAMP)
			reg_rdata <= ms_time;
		else
			reg_rdata <= '0;
	end

	// ----------------------------------------
	// stages
	// ----------------------------------------
	// [RL21] four stages
	for (genvar s = 0; s < NUM_STAGES; s++) begin : g_stage
		localparam logic [3:0] SEL = 4'(s);
		logic [2:0]           mode;
		logic [1:0]           force_sel;
		logic [15:0]          pickup_lvl;
		logic [15:0]          block_lvl;
		logic                 delay_inv;
		logic [31:0]          op_delay;
		logic [31:0]          dial;
		logic                 pickup;
		logic                 lowv_block;
		logic                 ext_q;
		logic                 trip;
		uvp_pkg::uvp_state_type state;
		uvp_pkg::uvp_seq_type   seq;
		logic [31:0]          ratio [3];
		logic [31:0]          ratio_min;
		logic [31:0]          inv_time;
		logic [31:0]          expected;
		logic [31:0]          remaining;
		logic [2:0]           below;
		logic [2:0]           above_rel;
		logic [2:0]           above_pu;
		logic [2:0]           below_blk;
		logic                 next_pickup;
		logic                 next_lowv_block;
		logic                 blocking;
		logic                 stage_wr;
		logic                 m_blocked;
		logic                 m_test;
		logic                 m_off;
		logic [31:0]          rd_word;
		logic [47:0]          pu_pri;
		logic [47:0]          blk_pri;
		logic                 start_q;
		logic                 trip_q;
		logic                 blocked_q;
		logic                 disp_q;
		logic                 bev_q;
		logic [31:0]          stamp_q;
		logic [2:0][15:0]     ev_v;
		logic [2:0]           ev_ft;

		uvp_div_if #(.W(32)) dv ();
		uvp_divider #(.W(32)) u_div (
			.ref_clk (ref_clk),
			.reset_n (reset_n),
			.dv      (dv.slave)
		);

		assign stage_wr = reg_wr && reg_addr[7:4] == SEL;

		// [RL1] mode decoding
		assign m_blocked = (mode == `UVP_MODE_BLOCKED) || (mode == `UVP_MODE_TESTBLK);
		assign m_test    = (mode == `UVP_MODE_TEST) || (mode == `UVP_MODE_TESTBLK);
		assign m_off     = (mode == `UVP_MODE_OFF);

		// [RL3] static settings
		// mode and force sit outside any setting bank
		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				mode      <= `UVP_MODE_ON;
				force_sel <= `UVP_FORCE_NORMAL;
			end else if (stage_wr && reg_addr[3:0] == `UVP_REG_MODE) begin
				// illegal codes are ignored so the mode stays defined
				if (reg_wdata[2:0] >= `UVP_MODE_ON && reg_wdata[2:0] <= `UVP_MODE_OFF)
					mode <= reg_wdata[2:0];
			end else if (stage_wr && reg_addr[3:0] == `UVP_REG_FORCE) begin
				force_sel <= reg_wdata[1:0];
			end
		end

		// [RL4] threshold and [RL9] block level settings
		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				pickup_lvl <= `UVP_PICKUP_RST;
				block_lvl  <= `UVP_BLKLVL_RST;
				delay_inv  <= 1'b0;
				op_delay   <= `UVP_OPDLY_RST;
				dial       <= `UVP_DIAL_RST;
			end else if (stage_wr) begin
				unique case (reg_addr[3:0])
					`UVP_REG_PICKUP: pickup_lvl <= reg_wdata[15:0];
					`UVP_REG_BLKLVL: block_lvl  <= reg_wdata[15:0];
					`UVP_REG_DTYPE:  delay_inv  <= reg_wdata[0];
					`UVP_REG_OPDLY:  op_delay   <= reg_wdata;
					`UVP_REG_DIAL:   dial       <= reg_wdata;
					default: ;
				endcase
			end
		end

		// per-voltage comparators
		for (genvar k = 0; k < 3; k++) begin : g_phase
			// [RL7] common threshold
			assign below[k]     = measured_voltage[k] < pickup_lvl;
			// [RL6] fixed release ratio
			assign above_rel[k] = ({8'h00, measured_voltage[k]} * `UVP_PCT_FULL) >
			                      ({8'h00, pickup_lvl} * `UVP_HYST_PCT);
			assign above_pu[k]  = measured_voltage[k] > pickup_lvl;
			assign below_blk[k] = measured_voltage[k] < block_lvl;
		end

		// [RL23] pick-up below threshold, release above hysteresis
		assign next_pickup   = (|below) ? 1'b1 : ((&above_rel) ? 1'b0 : pickup);
		// [RL10] latch set wins over release
		assign next_lowv_block = (block_lvl != '0 && (|below_blk)) ? 1'b1 :
		                         ((&above_pu || block_lvl == '0) ? 1'b0 : lowv_block);
		// [RL15] external block taken at the cycle tick
		assign blocking        = block_in[s] || next_lowv_block || m_blocked;

		// [RL5] ratio sequencing each program cycle
		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				seq    <= uvp_pkg::SEQ_IDLE;
				dv.go  <= 1'b0;
				dv.num <= '0;
				dv.den <= '0;
			end else begin
				dv.go <= 1'b0;
				if (prog_tick) begin
					seq    <= uvp_pkg::SEQ_PH0;
					dv.go  <= 1'b1;
					dv.num <= 32'({8'h00, measured_voltage[0]} * `UVP_PCT_FULL);
					dv.den <= {16'h0000, pickup_lvl};
				end else if (dv.done) begin
					unique case (seq)
						uvp_pkg::SEQ_PH0: begin
							seq    <= uvp_pkg::SEQ_PH1;
							dv.go  <= 1'b1;
							dv.num <= 32'({8'h00, measured_voltage[1]} * `UVP_PCT_FULL);
						end
						uvp_pkg::SEQ_PH1: begin
							seq    <= uvp_pkg::SEQ_PH2;
							dv.go  <= 1'b1;
							dv.num <= 32'({8'h00, measured_voltage[2]} * `UVP_PCT_FULL);
						end
						uvp_pkg::SEQ_PH2: begin
							// inverse time, exponent one: dial * threshold / (threshold - lowest)
							seq    <= uvp_pkg::SEQ_INV;
							dv.go  <= 1'b1;
							dv.num <= 32'(dial[15:0]) * 32'(pickup_lvl);
							dv.den <= (pickup_lvl > v_min) ? {16'h0000, pickup_lvl - v_min} : '0;
						end
						uvp_pkg::SEQ_INV:  seq <= uvp_pkg::SEQ_IDLE;
						uvp_pkg::SEQ_IDLE: seq <= uvp_pkg::SEQ_IDLE;
					endcase
				end
			end
		end

		// [RL14] ratio results
		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				ratio     <= '{default: '0};
				inv_time  <= '0;
			end else if (dv.done) begin
				unique case (seq)
					uvp_pkg::SEQ_PH0:  ratio[0]  <= dv.quo;
					uvp_pkg::SEQ_PH1:  ratio[1]  <= dv.quo;
					uvp_pkg::SEQ_PH2:  ratio[2]  <= dv.quo;
					uvp_pkg::SEQ_INV:  inv_time  <= dv.quo;
					uvp_pkg::SEQ_IDLE: ;
				endcase
			end
		end

		// [RL14] lowest ratio
		always_comb begin
			ratio_min = ratio[0];
			if (ratio[1] < ratio_min)
				ratio_min = ratio[1];
			if (ratio[2] < ratio_min)
				ratio_min = ratio[2];
		end

		// [RL12] expected time, inverse time capped at the longest delay
		assign expected = !delay_inv ? op_delay :
		                  ((inv_time > `UVP_OP_MAX) ? `UVP_OP_MAX : inv_time);

		// ----------------------------------------
		// pick-up, blocking and start decision
		// ----------------------------------------
		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				state     <= uvp_pkg::UVP_IDLE;
				pickup    <= 1'b0;
				lowv_block <= 1'b0;
				ext_q     <= 1'b0;
				trip      <= 1'b0;
				remaining <= '0;
			end else if (prog_tick) begin
				pickup   <= next_pickup;
				lowv_block <= next_lowv_block;
				ext_q    <= block_in[s];
				if (m_off) begin
					state     <= uvp_pkg::UVP_IDLE;
					trip      <= 1'b0;
					remaining <= '0;
				end else begin
					unique case (state)
						uvp_pkg::UVP_IDLE: begin
							// [RL8] pick-up alone is not start
							if (next_pickup && blocking) begin
								// [RL17] blocked pick-up
								state <= uvp_pkg::UVP_BLOCKED;
							end else if (next_pickup) begin
								// [RL16] start and load timer
								state     <= uvp_pkg::UVP_START;
								remaining <= expected;
							end
						end
						uvp_pkg::UVP_START: begin
							if (!next_pickup || blocking) begin
								// [RL18] drop start like a release
								state     <= blocking && next_pickup ? uvp_pkg::UVP_BLOCKED : uvp_pkg::UVP_IDLE;
								trip      <= 1'b0;
								remaining <= '0;
							end else if (remaining != '0) begin
								// [RL13] countdown in program cycles
								remaining <= remaining - 32'h1;
							end else begin
								trip <= 1'b1;
							end
						end
						uvp_pkg::UVP_BLOCKED: begin
							if (!next_pickup || !blocking)
								state <= uvp_pkg::UVP_IDLE;
						end
					endcase
				end
			end
		end

		// [RL2] forced status, test modes keep start and trip pins quiet unless forced
		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				start_q   <= 1'b0;
				trip_q    <= 1'b0;
				blocked_q <= 1'b0;
			end else begin
				start_q   <= (force_sel == `UVP_FORCE_START) || (force_sel == `UVP_FORCE_NORMAL &&
				             state == uvp_pkg::UVP_START && !m_test && !m_off);
				trip_q    <= (force_sel == `UVP_FORCE_TRIP) || (force_sel == `UVP_FORCE_NORMAL &&
				             trip && !m_test && !m_off);
				blocked_q <= (force_sel == `UVP_FORCE_BLOCK) || (force_sel == `UVP_FORCE_NORMAL &&
				             state == uvp_pkg::UVP_BLOCKED && !m_off);
			end
		end

		// [RL19] blocking events with voltages and fault type
		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				disp_q  <= 1'b0;
				bev_q   <= 1'b0;
				stamp_q <= '0;
				ev_v    <= '0;
				ev_ft   <= '0;
			end else begin
				disp_q <= 1'b0;
				bev_q  <= 1'b0;
				if (prog_tick && !m_off && state != uvp_pkg::UVP_BLOCKED && next_pickup && blocking) begin
					disp_q  <= 1'b1;
					bev_q   <= 1'b1;
					// [RL22] stamp from millisecond counter
					stamp_q <= ms_time;
					ev_v    <= measured_voltage;
					ev_ft   <= below;
				end
			end
		end

		// [RL11] primary volts in 0.1 V steps
		assign pu_pri  = ({32'h0, pickup_lvl} * {16'h0, vt_primary}) / `UVP_PU_FULL;
		assign blk_pri = ({32'h0, block_lvl} * {16'h0, vt_primary}) / `UVP_PU_FULL;

		// stage register read view
		always_comb begin
			rd_word = '0;
			unique case (reg_addr[3:0])
				`UVP_REG_MODE:     rd_word = {29'h0, mode};
				`UVP_REG_FORCE:    rd_word = {30'h0, force_sel};
				`UVP_REG_PICKUP:   rd_word = {16'h0, pickup_lvl};
				`UVP_REG_BLKLVL:   rd_word = {16'h0, block_lvl};
				`UVP_REG_DTYPE:    rd_word = {31'h0, delay_inv};
				`UVP_REG_OPDLY:    rd_word = op_delay;
				`UVP_REG_DIAL:     rd_word = dial;
				`UVP_REG_STATUS: begin
					// [RL1] mode in effect
					rd_word[2:0]             = mode;
					rd_word[`UVP_ST_PICKUP]  = pickup;
					rd_word[`UVP_ST_START]   = state == uvp_pkg::UVP_START;
					rd_word[`UVP_ST_TRIP]    = trip;
					rd_word[`UVP_ST_BLOCKED] = state == uvp_pkg::UVP_BLOCKED;
					rd_word[`UVP_ST_UVBLOCK] = lowv_block;
					rd_word[`UVP_ST_EXTBLK]  = ext_q;
				end
				`UVP_REG_RATIO0:   rd_word = ratio[0];
				`UVP_REG_RATIO1:   rd_word = ratio[1];
				`UVP_REG_RATIO2:   rd_word = ratio[2];
				`UVP_REG_RATIOMIN: rd_word = ratio_min;
				`UVP_REG_EXPECT:   rd_word = expected;
				`UVP_REG_REMAIN:   rd_word = remaining;
				`UVP_REG_PUPRI:    rd_word = pu_pri[31:0];
				`UVP_REG_BLKPRI:   rd_word = blk_pri[31:0];
			endcase
		end

		assign stage_rd[s]         = rd_word;
		assign start_out[s]        = start_q;
		assign trip_out[s]         = trip_q;
		assign blocked_out[s]      = blocked_q;
		assign display_event[s]    = disp_q;
		assign block_event[s]      = bev_q;
		assign event_stamp[s]      = stamp_q;
		assign event_voltage[s]    = ev_v;
		assign event_fault_type[s] = ev_ft;
	end
endmodule : uvp_stage
`default_nettype wire

// >>> test/uvp_stage_assertions.sv
`default_nettype none
// ----
// stage 0 output checks, event pairing across all stages
// ----
module uvp_stage_assertions (
	input wire logic             ref_clk,
	input wire logic             reset_n,
	input wire logic [3:0]       start_out,
	input wire logic [3:0]       trip_out,
	input wire logic [3:0]       blocked_out,
	input wire logic [3:0]       display_event,
	input wire logic [3:0]       block_event,
	input wire logic [3:0][31:0] event_stamp
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	// decisions move only on program ticks, so outputs hold between them
	evt_pair_a: assert property (display_event == block_event)
		else $error("display and block events differ");
	evt_pulse_a: assert property (block_event[0] |=> !block_event[0])
		else $error("block event longer than a cycle");
	// the event pulse leads the registered blocked pin by one cycle
	blk_event_a: assert property ($past(block_event[0]) == $rose(blocked_out[0]))
		else $error("blocked rise and event not together");
	excl_out_a: assert property (!(start_out[0] && blocked_out[0]))
		else $error("start and blocked both high");
	trip_start_a: assert property (trip_out[0] |-> start_out[0])
		else $error("trip without start");
	start_hold_a: assert property ($rose(start_out[0]) |=> $stable(start_out[0])[*8])
		else $error("start changed between ticks");
	start_drop_a: assert property ($fell(start_out[0]) && blocked_out[0] |-> $past(block_event[0]))
		else $error("start dropped to blocked without event");
	stamp_hold_a: assert property (!block_event[0] |-> $stable(event_stamp[0]))
		else $error("stamp moved without event");
endmodule : uvp_stage_assertions
bind uvp_stage uvp_stage_assertions chk (.ref_clk, .reset_n, .start_out, .trip_out,
	.blocked_out, .display_event, .block_event, .event_stamp);
`default_nettype wire

// >>> test/uvp_source_model.sv
`default_nettype none
// ----
// measurement chain and blocking matrix
// ----
module uvp_source_model (
	input  wire logic             ref_clk,
	input  wire logic [2:0][15:0] want_v,
	input  wire logic [3:0]       want_blk,
	output var  logic [2:0][15:0] measured_voltage = {3{16'h2328}},
	output var  logic [3:0]       block_in = 4'h0
);
	timeunit 1ns;
	timeprecision 1ns;
	// rms values settle one clock after the bench asks
	always @(posedge ref_clk) begin
		measured_voltage <= want_v;
	end
	// block ahead of delay
	// the bench blocks ticks before any trip could fall due
	always @(posedge ref_clk) begin
		block_in <= want_blk;
	end
endmodule : uvp_source_model
`default_nettype wire

// >>> test/uvp_stage_bench.sv
`default_nettype none
// ----
// stage bench
// ----
module uvp_stage_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TICK = 256;
	logic                  ref_clk = 1'b0;
	logic                  reset_n = 1'b0;
	logic [7:0]            reg_addr = 8'h00;
	logic [31:0]           reg_wdata = 32'h0;
	logic                  reg_wr = 1'b0;
	logic                  reg_rd = 1'b0;
	logic [31:0]           reg_rdata;
	logic [2:0][15:0]      want_v = {3{16'h2328}};
	logic [3:0]            want_blk = 4'h0;
	logic [2:0][15:0]      measured_voltage;
	logic [3:0]            block_in, start_out, trip_out, blocked_out, display_event, block_event;
	logic [3:0][31:0]      event_stamp;
	logic [3:0][2:0][15:0] event_voltage;
	logic [3:0][2:0]       event_fault_type;
	int                    n_fail = 0;
	int                    tests_run = 0;
	int                    n_evt = 0;
	int                    cyc = 0;
	// 10 mhz clock
	always #50 ref_clk = ~ref_clk;
	uvp_source_model src (.ref_clk, .want_v, .want_blk, .measured_voltage, .block_in);
	// short tick keeps the run small; divider still fits inside one tick
	uvp_stage #(.PROG_CYCLES(TICK), .MS_CYCLES(16)) uut (.ref_clk, .reset_n, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .measured_voltage, .block_in, .start_out, .trip_out,
		.blocked_out, .display_event, .block_event, .event_stamp, .event_voltage, .event_fault_type);
	// count stage 0 events and cut a hang short
	always @(posedge ref_clk) begin
		if (block_event[0] === 1'b1)
			n_evt++;
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		chk(reg_rdata, exp);
		@(posedge ref_clk);
	endtask : rd
	task automatic ticks(input int n);
		repeat (n * TICK) @(posedge ref_clk);
	endtask : ticks
	// pins of one stage as blocked, trip, start
	task automatic outs(input int s, input logic [2:0] exp);
		@(negedge ref_clk);
		chk({29'h0, blocked_out[s], trip_out[s], start_out[s]}, {29'h0, exp});
		@(posedge ref_clk);
	endtask : outs
	task automatic finish_test();
		$display("mismatches %0d of %0d checks", n_fail, tests_run);
		if (n_fail == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test
	// main sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		rd(8'h00, 32'h1); // mode on after reset
		rd(8'h01, 32'h0); // force normal
		rd(8'h02, 32'h1770); // sixty percent
		rd(8'h03, 32'h03e8); // ten percent
		rd(8'h42, 32'h0);
		wr(8'h00, 32'h7);
		rd(8'h00, 32'h1); // bad mode ignored
		wr(8'h40, 32'h4e20);
		ticks(2);
		rd(8'h08, 32'h96); // ratio per phase
		rd(8'h0e, 32'h2ee0); // primary pick-up
		rd(8'h0f, 32'h07d0); // primary block level
		for (int m = 1; m <= 5; m++) begin
			wr(8'h20, 32'(m));
			ticks(1);
			rd(8'h27, 32'(m)); // mode in effect
		end
		wr(8'h20, 32'h1);
		for (int f = 1; f <= 3; f++) begin
			wr(8'h31, 32'(f));
			ticks(1);
			outs(3, 3'(1 << (f - 1))); // forced pin
		end
		wr(8'h31, 32'h0);
		want_blk <= 4'h2;
		ticks(2);
		rd(8'h17, 32'h101); // block sampled
		want_blk <= 4'h0;
		want_v[2] <= 16'h12c0;
		ticks(2);
		outs(0, 3'b001); // start when unblocked
		rd(8'h07, 32'h19); // one low voltage picks up
		rd(8'h0b, 32'h50); // lowest ratio
		rd(8'h0c, 32'h8); // expected time
		ticks(10);
		outs(0, 3'b011); // trip after delay
		want_v[2] <= 16'h17e8;
		ticks(2);
		outs(0, 3'b011); // inside hysteresis
		rd(8'h0a, 32'h66); // ratio of phase
		want_v[2] <= 16'h1838;
		ticks(2);
		outs(0, 3'b000); // release above ratio
		want_blk <= 4'h1;
		ticks(1);
		want_v[1] <= 16'h12c0;
		ticks(2);
		outs(0, 3'b100); // blocked pick-up
		chk(32'(n_evt), 32'h1); // one event
		chk({16'h0, event_voltage[0][1]}, 32'h12c0); // voltage carried
		chk({29'h0, event_fault_type[0]}, 32'h2); // fault type
		chk(event_stamp[0], 32'h1df); // stamp in ms
		want_blk <= 4'h0;
		ticks(3);
		outs(0, 3'b001); // start once block ends
		want_blk <= 4'h1;
		ticks(2);
		outs(0, 3'b100); // start dropped on block
		chk(32'(n_evt), 32'h2); // second event
		want_blk <= 4'h0;
		want_v[1] <= 16'h2328;
		ticks(2);
		want_v[0] <= 16'h01f4;
		ticks(2);
		outs(0, 3'b100); // dead network blocks
		want_v[0] <= 16'h170c;
		ticks(2);
		rd(8'h07, 32'hc9); // latch holds below pick-up
		want_v[0] <= 16'h2328;
		ticks(2);
		outs(0, 3'b000); // latch clears on recovery
		wr(8'h03, 32'h0);
		want_v[0] <= 16'h01f4;
		ticks(2);
		outs(0, 3'b001); // zero level disables block
		wr(8'h04, 32'h1);
		ticks(2);
		rd(8'h0c, 32'ha); // inverse expected time
		rd(8'h0d, 32'h5); // ticks left to trip
		want_v[0] <= 16'h0bb8;
		ticks(2);
		rd(8'h0c, 32'h14); // recomputed on new voltage
		finish_test();
	end
endmodule : uvp_stage_bench
`default_nettype wire
